// *** bcd_bit_if.sv ***
// interface: bit-operation request and result between decoder and bit unit
`timescale 1ns/10ps
interface bcd_bit_if;
    logic [2:0] bitIdx;
    logic [7:0] srcVal;
    logic [1:0] op;
    logic [7:0] result;
    logic bitVal;
    modport master (output bitIdx, output srcVal, output op,
        input result, input bitVal);
    modport unit (input bitIdx, input srcVal, input op,
        output result, output bitVal);
endinterface

// *** bcd_bit_unit.sv ***
// module: per-bit clear, set and toggle of a file byte, plus bit sample
`timescale 1ns/10ps
module bcd_bit_unit (
    bcd_bit_if.unit bi
);
    // op 0 clear, 1 set, 2 toggle, 3 pass through
    genvar g;
    generate
        for (g = 0; g < 8; g++)
        begin : gBit
            logic hit;
            assign hit = (bi.bitIdx == 3'(g));
            assign bi.result[g] = !hit ? bi.srcVal[g] :
                (bi.op == 2'h0) ? 1'b0 :
                (bi.op == 2'h1) ? 1'b1 :
                (bi.op == 2'h2) ? ~bi.srcVal[g] : bi.srcVal[g];
        end
    endgenerate
    assign bi.bitVal = bi.srcVal[bi.bitIdx];
endmodule

// *** bcd_decoder.sv ***
// module: bit and control-flow instruction decoder and sequencer
`timescale 1ns/10ps
// Contract
// [RQ1] clear, set, toggle bit: one cycle
// [RQ2] bit test skips next, two or three cycles
// [RQ3] conditional branch by condition nibble, flags untouched
// [RQ4] nonzero branch adds twice signed offset
// [RQ5] target is pc plus two plus 2n
// [RQ6] pc change or true test adds flush cycle
// [RQ7] absolute call: two words, shadow select bit
// [RQ8] long jump: two words, two cycles; code takes three, the second word then a flush cycle
// [RQ9] top nibble 1111 alone is no-op
// [RQ10] second word consumed as operand, else no-op
// [RQ11] push and pop on stack top, one cycle
// [RQ12] interrupt return re-enables both irq enables
// [RQ13] literal return loads working register; return
// [RQ14] sleep and watchdog clear update flags
// [RQ15] port bit ops read pin levels
// [RQ16] timer-zero bit write clears prescaler
// [RQ17] shadow bit zero none, one transfers
// [RQ18] offsets sign-extended before doubling
module bcd_decoder (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic clkEn,
    input wire logic [15:0] instrWord,
    input wire logic instrValid,
    input wire logic [7:0] fileRdData,
    input wire logic [7:0] pinLevels,
    input wire logic prescalerOnTimer,
    input wire logic flagZero,
    input wire logic flagCarry,
    input wire logic flagOverflow,
    input wire logic flagNegative,
    input wire logic [20:0] stackTopData,
    output logic [20:0] pcOut,
    output logic fetchFlush,
    output logic [7:0] fileAddr,
    output logic fileAccessSel,
    output logic [7:0] fileWrData,
    output logic fileWrEn,
    output logic prescalerClear,
    output logic stackPush,
    output logic stackPop,
    output logic [20:0] stackPushData,
    output logic shadowSave,
    output logic shadowRestore,
    output logic globalIrqEnableSet,
    output logic peripheralIrqEnableSet,
    output logic [7:0] workingRegData,
    output logic workingRegWrEn,
    output logic watchdogClear,
    output logic sleepEnter,
    output logic watchdogExpiredFlag,
    output logic powerdownFlag,
    output logic softReset,
    output logic busy
);
    // sequencing state: execute, flush after a pc change, or wait for the
    // second word of a two-word call or jump
    localparam int W = bcd_pkg::PC_W;
    bcd_pkg::bcd_state_t state_q, state_d;
    logic [W-1:0] pc_q, pc_d;
    logic [1:0] flush_q, flush_d;
    logic second_q, second_d;
    logic [7:0] hiAddr_q, hiAddr_d;
    logic isCall_q, isCall_d;
    logic shadow_q, shadow_d;
    logic skipNext_q, skipNext_d;

    bcd_bit_if bif ();
    bcd_bit_unit uBit (.bi(bif));

    logic [3:0] nib;
    logic [3:0] cond;
    logic isBitOp, isSkip, isCondBr, isRel, isAbsCall, isJump;
    logic isLitRet, isIret, isRet, condTrue, isPort;
    logic [W-1:0] pcNext, relTarget8, relTarget11;
    logic [W-1:0] absTarget;

    // opcode decode: top nibble picks the class, next nibble refines it;
    // every class is decoded from the word as presented, so a stalled fetch
    // must keep instrValid low rather than show a half-updated word
    assign nib = instrWord[15:12];
    assign cond = instrWord[11:8];
    assign isBitOp = (nib == bcd_pkg::NIB_BCLR) ||
        (nib == bcd_pkg::NIB_BSET) || (nib == bcd_pkg::NIB_BTGL); // [RQ1]
    assign isSkip = (nib == bcd_pkg::NIB_SKC) ||
        (nib == bcd_pkg::NIB_SKS); // [RQ2]
    assign isCondBr = (nib == bcd_pkg::NIB_COND) && !cond[3]; // [RQ3]
    assign isRel = (nib == bcd_pkg::NIB_REL); // [RQ6]
    assign isAbsCall = (nib == bcd_pkg::NIB_COND) &&
        (cond[3:1] == bcd_pkg::CALL_SUB); // [RQ7]
    assign isJump = (nib == bcd_pkg::NIB_COND) &&
        (cond == bcd_pkg::JUMP_SUB); // [RQ8]
    assign isLitRet = (nib == bcd_pkg::NIB_ZERO) &&
        (cond == bcd_pkg::NIB_LITRET); // [RQ13]
    assign isIret = (instrWord[15:1] == bcd_pkg::OP_IRET); // [RQ12]
    assign isRet = (instrWord[15:1] == bcd_pkg::OP_RET); // [RQ13]
    assign isPort = (instrWord[7:0] >= bcd_pkg::PORT_LO_ADDR) &&
        (instrWord[7:0] <= bcd_pkg::PORT_HI_ADDR);

    // condition select: odd nibble is the negated sense
    always_comb
    begin
        case (cond[2:1])
            2'h0: condTrue = flagZero ^ cond[0]; // [RQ4]
            2'h1: condTrue = flagCarry ^ cond[0];
            2'h2: condTrue = flagOverflow ^ cond[0];
            default: condTrue = flagNegative ^ cond[0];
        endcase
    end

    // pc still points at this word, so step past it; sign-extend then double
    assign pcNext = pc_q + bcd_pkg::PC_STEP; // [RQ5]
    assign relTarget8 = pcNext + W'({{(W-9){instrWord[7]}},
        instrWord[7:0], 1'b0}); // [RQ18] [RQ4]
    assign relTarget11 = pcNext + W'({{(W-12){instrWord[10]}},
        instrWord[10:0], 1'b0}); // [RQ18]
    assign absTarget = {hiAddr_q[7:0], instrWord[11:0], 1'b0};

    // bit unit operand select; port addresses read the pins
    assign bif.bitIdx = instrWord[11:9];
    assign bif.srcVal = isPort ? pinLevels : fileRdData; // [RQ15]
    assign bif.op = (nib == bcd_pkg::NIB_BCLR) ? 2'h0 :
        (nib == bcd_pkg::NIB_BSET) ? 2'h1 :
        (nib == bcd_pkg::NIB_BTGL) ? 2'h2 : 2'h3;

    // a word is acted on only in plain execute with a valid fetch
    logic execNow;
    assign execNow = clkEn && instrValid && (state_q == bcd_pkg::ST_EXEC);

    // sequencing: next pc, flush cycles and two-word tracking
    always_comb
    begin
        state_d = state_q;
        pc_d = pc_q;
        flush_d = flush_q;
        second_d = second_q;
        hiAddr_d = hiAddr_q;
        isCall_d = isCall_q;
        shadow_d = shadow_q;
        skipNext_d = skipNext_q;
        case (state_q)
            bcd_pkg::ST_EXEC:
            begin
                if (instrValid)
                begin
                    pc_d = pcNext;
                    if (skipNext_q)
                    begin
                        // skipped word runs as a flush; two-word target adds one
                        skipNext_d = 1'b0;
                        if (isAbsCall || isJump)
                            state_d = bcd_pkg::ST_SECOND; // [RQ2]
                    end
                    else if (isSkip && (bif.bitVal == (nib == bcd_pkg::NIB_SKS)))
                        skipNext_d = 1'b1; // [RQ2] [RQ6]
                    else if (isCondBr && condTrue)
                    begin
                        pc_d = relTarget8; // [RQ3] [RQ4] [RQ6]
                        state_d = bcd_pkg::ST_FLUSH;
                    end
                    else if (isRel)
                    begin
                        pc_d = relTarget11; // [RQ6]
                        state_d = bcd_pkg::ST_FLUSH;
                    end
                    else if (isAbsCall || isJump)
                    begin
                        hiAddr_d = instrWord[7:0]; // [RQ7] [RQ8] [RQ10]
                        isCall_d = isAbsCall;
                        shadow_d = isAbsCall && instrWord[8]; // [RQ17]
                        second_d = 1'b1;
                        state_d = bcd_pkg::ST_SECOND;
                    end
                    else if (isIret || isRet || isLitRet)
                    begin
                        pc_d = stackTopData; // [RQ12] [RQ13]
                        state_d = bcd_pkg::ST_FLUSH;
                    end
                end
            end
            bcd_pkg::ST_SECOND:
            begin
                if (instrValid)
                begin
                    if (second_q && nib == bcd_pkg::NIB_SECOND)
                    begin
                        pc_d = absTarget; // [RQ10]
                        state_d = bcd_pkg::ST_FLUSH;
                    end
                    else
                    begin
                        pc_d = pcNext; // [RQ9]
                        state_d = bcd_pkg::ST_EXEC;
                    end
                    second_d = 1'b0;
                end
            end
            default:
                state_d = bcd_pkg::ST_EXEC; // [RQ6]
        endcase
        flush_d = 2'(state_d == bcd_pkg::ST_FLUSH);
    end

    // state registers, frozen while clock enable is low
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            state_q <= bcd_pkg::ST_EXEC;
            pc_q <= bcd_pkg::PC_RESET;
            flush_q <= 2'h0;
            second_q <= 1'b0;
            hiAddr_q <= 8'h00;
            isCall_q <= 1'b0;
            shadow_q <= 1'b0;
            skipNext_q <= 1'b0;
        end
        else if (clkEn)
        begin
            state_q <= state_d;
            pc_q <= pc_d;
            flush_q <= flush_d;
            second_q <= second_d;
            hiAddr_q <= hiAddr_d;
            isCall_q <= isCall_d;
            shadow_q <= shadow_d;
            skipNext_q <= skipNext_d;
        end
    end

    // live: the word really executes; a skipped word only moves the pc,
    // so every side effect below except the call push and shadow save is gated by this one term
    logic live;
    assign live = execNow && !skipNext_q;
    // second word of an absolute call: push and shadow save happen here,
    // once the full target is known, so a skipped call never pushes
    logic secondCall;
    assign secondCall = clkEn && instrValid && second_q &&
        (state_q == bcd_pkg::ST_SECOND) && nib == bcd_pkg::NIB_SECOND &&
        isCall_q;

    // registered side effects: one-cycle write and prescaler-clear pulses, held address and data
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            fileAddr <= 8'h00;
            fileAccessSel <= 1'b0;
            fileWrData <= 8'h00;
            fileWrEn <= 1'b0;
            prescalerClear <= 1'b0;
        end
        else if (clkEn)
        begin
            fileWrEn <= live && isBitOp; // [RQ1]
            prescalerClear <= live && isBitOp && prescalerOnTimer &&
                (instrWord[7:0] == bcd_pkg::TIMER_ZERO_ADDR); // [RQ16]
            if (live && isBitOp)
            begin
                fileAddr <= instrWord[7:0];
                fileAccessSel <= instrWord[8];
                fileWrData <= bif.result; // [RQ15]
            end
        end
    end

    // stack, shadow and interrupt-enable side effects
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            stackPush <= 1'b0;
            stackPop <= 1'b0;
            stackPushData <= 21'h000000;
            shadowSave <= 1'b0;
            shadowRestore <= 1'b0;
            globalIrqEnableSet <= 1'b0;
            peripheralIrqEnableSet <= 1'b0;
            workingRegData <= 8'h00;
            workingRegWrEn <= 1'b0;
        end
        else if (clkEn)
        begin
            stackPush <= (live && (instrWord == bcd_pkg::OP_PUSH ||
                isRel && instrWord[11])) || secondCall; // [RQ11] [RQ7]
            stackPop <= live && (instrWord == bcd_pkg::OP_POP ||
                isIret || isRet || isLitRet); // [RQ11] [RQ13]
            if (live && isRel)
                stackPushData <= pcNext;
            else if (live && instrWord == bcd_pkg::OP_PUSH)
                stackPushData <= pcNext;
            else if (secondCall)
                stackPushData <= pcNext;
            shadowSave <= secondCall && shadow_q; // [RQ17]
            shadowRestore <= live && (isIret || isRet) &&
                instrWord[0]; // [RQ12] [RQ17]
            globalIrqEnableSet <= live && isIret; // [RQ12]
            peripheralIrqEnableSet <= live && isIret; // [RQ12]
            workingRegWrEn <= live && isLitRet; // [RQ13]
            if (live && isLitRet)
                workingRegData <= instrWord[7:0];
        end
    end

    // power control: flags follow the wake-state convention, set means clear
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            watchdogClear <= 1'b0;
            sleepEnter <= 1'b0;
            watchdogExpiredFlag <= 1'b1;
            powerdownFlag <= 1'b1;
            softReset <= 1'b0;
        end
        else if (clkEn)
        begin
            watchdogClear <= live && (instrWord == bcd_pkg::OP_WDTCLR ||
                instrWord == bcd_pkg::OP_SLEEP); // [RQ14]
            sleepEnter <= live && instrWord == bcd_pkg::OP_SLEEP;
            softReset <= live && instrWord == bcd_pkg::OP_RESET;
            if (live && instrWord == bcd_pkg::OP_WDTCLR)
            begin
                watchdogExpiredFlag <= 1'b1; // [RQ14]
                powerdownFlag <= 1'b1;
            end
            else if (live && instrWord == bcd_pkg::OP_SLEEP)
            begin
                watchdogExpiredFlag <= 1'b1; // [RQ14]
                powerdownFlag <= 1'b0;
            end
        end
    end

    // outputs straight from flops; busy is combinational so the fetch side
    // sees a pending skip or flush in the same cycle
    assign pcOut = pc_q;
    assign fetchFlush = flush_q[0]; // [RQ6]
    assign busy = (state_q != bcd_pkg::ST_EXEC) || skipNext_q;
endmodule

// *** bcd_decoder_chk.sv ***
// checker: timing and value relations at the decoder ports
`timescale 1ns/10ps
module bcd_decoder_chk (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic clkEn,
    input wire logic [15:0] instrWord,
    input wire logic instrValid,
    input wire logic [7:0] fileRdData,
    input wire logic [7:0] pinLevels,
    input wire logic prescalerOnTimer,
    input wire logic flagZero,
    input wire logic flagCarry,
    input wire logic flagOverflow,
    input wire logic flagNegative,
    input wire logic [20:0] stackTopData,
    input wire logic [20:0] pcOut,
    input wire logic fetchFlush,
    input wire logic [7:0] fileAddr,
    input wire logic fileAccessSel,
    input wire logic sleepEnter,
    input wire logic [7:0] fileWrData,
    input wire logic fileWrEn,
    input wire logic prescalerClear,
    input wire logic stackPush,
    input wire logic stackPop,
    input wire logic shadowRestore,
    input wire logic globalIrqEnableSet,
    input wire logic peripheralIrqEnableSet,
    input wire logic [7:0] workingRegData,
    input wire logic workingRegWrEn,
    input wire logic watchdogClear,
    input wire logic watchdogExpiredFlag,
    input wire logic powerdownFlag,
    input wire logic busy
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    logic take, isBit, isCond, isPort, hit;
    logic [3:0] nib;
    logic [7:0] src, mask, expWr;
    logic [20:0] relTgt, braTgt;
    // a word counts only when taken in plain execute
    assign nib = instrWord[15:12];
    assign take = clkEn && instrValid && !busy;
    assign isBit = nib == 4'h9 || nib == 4'h8 || nib == 4'h7;
    assign isCond = nib == 4'he && !instrWord[11];
    assign isPort = instrWord[7:0] >= bcd_pkg::PORT_LO_ADDR
        && instrWord[7:0] <= bcd_pkg::PORT_HI_ADDR;
    // bit 8 inverts the flag picked by bits 10:9
    assign hit = instrWord[8] ^ (instrWord[10]
        ? (instrWord[9] ? flagNegative : flagOverflow)
        : (instrWord[9] ? flagCarry : flagZero));
    // ports read back pins, not the latch
    assign src = isPort ? pinLevels : fileRdData;
    assign mask = 8'h01 << instrWord[11:9];
    assign expWr = nib == 4'h9 ? src & ~mask
        : (nib == 4'h8 ? src | mask : src ^ mask);
    // offsets sign-extended, doubled, on top of pc plus two
    assign relTgt = pcOut + 21'h2 + {{12{instrWord[7]}}, instrWord[7:0], 1'b0};
    assign braTgt = pcOut + 21'h2 + {{9{instrWord[10]}}, instrWord[10:0], 1'b0};
    property p_bit_write;
        take && isBit |=> fileWrEn && fileAddr == $past(instrWord[7:0])
            && fileAccessSel == $past(instrWord[8])
            && fileWrData == $past(expWr);
    endproperty
    a_bit_write: assert property (p_bit_write)
        else $error("bit write wrong");
    property p_prescaler;
        take && isBit && prescalerOnTimer
            && instrWord[7:0] == bcd_pkg::TIMER_ZERO_ADDR |=> prescalerClear;
    endproperty
    a_prescaler: assert property (p_prescaler)
        else $error("prescaler not cleared");
    property p_skip;
        take && !isPort && (nib == 4'hb || nib == 4'ha)
            && fileRdData[instrWord[11:9]] == (nib == 4'ha) |=> busy && !fileWrEn;
    endproperty
    a_skip: assert property (p_skip)
        else $error("skip not taken");
    property p_cond;
        take && isCond |=> fetchFlush == $past(hit) && pcOut ==
            ($past(hit) ? $past(relTgt) : $past(pcOut) + 21'h2);
    endproperty
    a_cond: assert property (p_cond)
        else $error("conditional branch wrong");
    property p_rel;
        take && nib == 4'hd |=> fetchFlush && pcOut == $past(braTgt);
    endproperty
    a_rel: assert property (p_rel)
        else $error("relative branch wrong");
    property p_flush;
        fetchFlush && clkEn && instrValid |=> !fetchFlush && $stable(pcOut);
    endproperty
    a_flush: assert property (p_flush)
        else $error("flush cycle wrong");
    property p_stack;
        take && (instrWord == bcd_pkg::OP_PUSH || instrWord == bcd_pkg::OP_POP)
            |=> stackPush == $past(instrWord[0]) && stackPop != stackPush;
    endproperty
    a_stack: assert property (p_stack)
        else $error("stack pulse wrong");
    property p_wdt;
        take && instrWord == bcd_pkg::OP_WDTCLR
            |=> watchdogClear && watchdogExpiredFlag && powerdownFlag;
    endproperty
    a_wdt: assert property (p_wdt)
        else $error("watchdog clear wrong");
    property p_sleep;
        take && instrWord == bcd_pkg::OP_SLEEP
            |=> sleepEnter && watchdogExpiredFlag && !powerdownFlag;
    endproperty
    a_sleep: assert property (p_sleep)
        else $error("sleep entry wrong");
    property p_iret;
        take && instrWord[15:1] == bcd_pkg::OP_IRET |=> globalIrqEnableSet
            && peripheralIrqEnableSet && pcOut == $past(stackTopData)
            && shadowRestore == $past(instrWord[0]);
    endproperty
    a_iret: assert property (p_iret)
        else $error("interrupt return wrong");
    property p_litret;
        take && instrWord[15:8] == 8'h0c |=> workingRegWrEn
            && workingRegData == $past(instrWord[7:0]);
    endproperty
    a_litret: assert property (p_litret)
        else $error("literal return wrong");
endmodule
bind bcd_decoder bcd_decoder_chk bcd_decoder_chk_inst (.*);

// *** bcd_decoder_tb.sv ***
// testbench: runs a short program through the decoder and scores results
`timescale 1ns/10ps
module bcd_decoder_tb;
    // filler 8001 would write a byte if a skipped word ever ran
    localparam logic [15:0] PROG [38] = '{
        16'h8655, 16'h9e56, 16'h7081, 16'h72d6, 16'ha010, 16'hef12,
        16'hf034, 16'hb110, 16'he103, 16'h8001, 16'h8001, 16'h8001,
        16'he000, 16'he100, 16'he200, 16'he300, 16'he400, 16'he500,
        16'he600, 16'he700, 16'hd003, 16'h8001, 16'h8001, 16'h8001,
        16'h0005, 16'h0006, 16'h0004, 16'h0003, 16'h0011, 16'h8001,
        16'h8001, 16'h8001, 16'hef00, 16'hf024, 16'h8001, 16'h8001,
        16'hf123, 16'h0c5a};
    logic ref_clk, sys_rst, clkEn, slow, prescalerOnTimer, instrValid;
    logic fetchFlush, fileWrEn, workingRegWrEn, watchdogExpiredFlag;
    logic edgeEn, live, done;
    logic [15:0] instrWord;
    logic [7:0] fileRdData, pinLevels, fileAddr, fileWrData, workingRegData;
    logic [20:0] pcOut, prevPc;
    logic [15:0] qWr [$];
    logic [20:0] qPc [$];
    int failures, num_checks, seed;
    bcd_prog_mem bcd_prog_mem_inst (.*);
    bcd_decoder bcd_decoder_inst (.*, .flagZero(1'b0), .flagCarry(1'b0),
        .flagOverflow(1'b0), .flagNegative(1'b0), .stackTopData(21'h000040),
        .fileAccessSel(), .prescalerClear(), .stackPush(), .stackPop(),
        .stackPushData(), .shadowSave(), .shadowRestore(), .softReset(),
        .globalIrqEnableSet(), .peripheralIrqEnableSet(), .watchdogClear(),
        .sleepEnter(), .powerdownFlag(), .busy());
    task automatic check(input logic [20:0] seen, input logic [20:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("mismatch at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop;
        $display("checks %0d, mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial
    begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    // results only move on enabled edges
    always @(posedge ref_clk)
        edgeEn <= clkEn;
    // random stalls and slow fetches once the program runs
    always @(posedge ref_clk)
    begin
        if (live)
        begin
            clkEn <= ($random(seed) & 3) != 0;
            slow <= 1'($random(seed));
            prescalerOnTimer <= 1'($random(seed));
        end
    end
    // scoreboard: every write or pc jump takes the oldest note
    always @(negedge ref_clk)
    begin
        if (live && edgeEn)
        begin
            if (fileWrEn)
                check({fileAddr, fileWrData}, qWr.size() ? qWr.pop_front() : 'x);
            if (pcOut !== prevPc && pcOut !== prevPc + 21'h2)
                check(pcOut, qPc.size() ? qPc.pop_front() : 'x);
            prevPc = pcOut;
            if (workingRegWrEn)
            begin
                check(workingRegData, 8'h5a);
                check(qWr.size() + qPc.size(), 0);
                done = 1'b1;
            end
        end
    end
    initial
    begin
        seed = 32'h3e9b;
        sys_rst = 1'b1;
        clkEn = 1'b1;
        slow = 1'b0;
        live = 1'b0;
        done = 1'b0;
        prescalerOnTimer = 1'b1;
        prevPc = 21'h0;
        fileRdData = 8'($random(seed)) | 8'h01;
        pinLevels = 8'($random(seed));
        foreach (bcd_prog_mem_inst.mem[i])
            bcd_prog_mem_inst.mem[i] = i < 38 ? PROG[i] : 16'h8001;
        // ports use pins, timer zero gets bit 1 toggled
        qWr = '{{8'h55, fileRdData | 8'h08}, {8'h56, fileRdData & 8'h7f},
            {8'h81, pinLevels ^ 8'h01}, {8'hd6, fileRdData ^ 8'h02}};
        qPc = '{21'h18, 21'h30, 21'h40, 21'h48, 21'h40};
        repeat (3) @(posedge ref_clk);
        sys_rst <= 1'b0;
        @(posedge ref_clk);
        #1;
        check(watchdogExpiredFlag, 1'b1);
        live <= 1'b1;
        wait (done === 1'b1);
        report_and_stop();
    end
    // a hang is cut short well past the program length
    initial
    begin
        repeat (2000) @(posedge ref_clk);
        failures++;
        report_and_stop();
    end
endmodule

// *** bcd_pkg.sv ***
// package: opcode fields, encodings and sequencing constants for the decoder
package bcd_pkg;
    localparam int PC_W = 21;
    localparam logic [3:0] NIB_BCLR = 4'h9;
    localparam logic [3:0] NIB_BSET = 4'h8;
    localparam logic [3:0] NIB_BTGL = 4'h7;
    localparam logic [3:0] NIB_SKC = 4'hb;
    localparam logic [3:0] NIB_SKS = 4'ha;
    localparam logic [3:0] NIB_COND = 4'he;
    localparam logic [3:0] NIB_REL = 4'hd;
    localparam logic [3:0] NIB_SECOND = 4'hf;
    localparam logic [3:0] NIB_LITRET = 4'hc;
    localparam logic [3:0] NIB_ZERO = 4'h0;
    localparam logic [2:0] CALL_SUB = 3'h6;
    localparam logic [3:0] JUMP_SUB = 4'hf;
    localparam logic [15:0] OP_PUSH = 16'h0005;
    localparam logic [15:0] OP_POP = 16'h0006;
    localparam logic [15:0] OP_WDTCLR = 16'h0004;
    localparam logic [15:0] OP_SLEEP = 16'h0003;
    localparam logic [15:0] OP_RESET = 16'h00ff;
    localparam logic [14:0] OP_IRET = 15'h0008;
    localparam logic [14:0] OP_RET = 15'h0009;
    localparam logic [7:0] TIMER_ZERO_ADDR = 8'hd6;
    localparam logic [7:0] PORT_LO_ADDR = 8'h80;
    localparam logic [7:0] PORT_HI_ADDR = 8'h84;
    localparam logic [PC_W-1:0] PC_STEP = 21'h000002;
    localparam logic [PC_W-1:0] PC_RESET = 21'h000000;
    typedef enum logic [2:0]
    {
        ST_EXEC = 3'b001,
        ST_FLUSH = 3'b010,
        ST_SECOND = 3'b100
    } bcd_state_t;
endpackage

// *** bcd_prog_mem.sv ***
// model: program memory answering fetches at the program counter
`timescale 1ns/10ps
module bcd_prog_mem (
    input wire logic ref_clk,
    input wire logic slow,
    input wire logic [20:0] pcOut,
    output logic [15:0] instrWord,
    output logic instrValid
);
    logic [15:0] mem [0:63];
    logic tgl_q = 1'b0;
    // slow mode answers every other cycle, like a wait state
    always_ff @(posedge ref_clk)
        tgl_q <= ~tgl_q;
    assign instrValid = !slow || tgl_q;
    // no valid word: show the inverse so a stale word never passes
    assign instrWord = instrValid ? mem[pcOut[6:1]] : ~mem[pcOut[6:1]];
endmodule
